// *** ccd_defines.svh ***
`ifndef CCD_DEFINES_SVH
`define CCD_DEFINES_SVH
// register offsets
`define CCD_OFS_CAL 10'h018
`define CCD_OFS_ZD 10'h01E
`define CCD_OFS_STAT 10'h01F
`define CCD_OFS_DLY 10'h020
`define CCD_OFS_CH0 10'h190
`define CCD_CH_STRIDE 10'h003
`define CCD_OFS_PREDIV 10'h1E0
`define CCD_OFS_SRC 10'h1E1
// field positions
`define CCD_CAL_REQ_BIT 0
`define CCD_CAL_DIV_LSB 1
`define CCD_ZD_MODE_LSB 1
`define CCD_ZD_FBSEL_LSB 3
`define CCD_STAT_DONE_BIT 6
`define CCD_DLY_FB_LSB 3
`define CCD_CH_BYP_BIT 7
`define CCD_CH_START_BIT 4
`define CCD_CH_DCC_BIT 0
`define CCD_CH_DIRECT_BIT 1
// field values and reset values
`define CCD_ZD_INT 2'h1
`define CCD_ZD_EXT 2'h3
`define CCD_PREDIV_MAX 3'h5
`define CCD_PREDIV_RST 3'h1
`define CCD_MN_RST 4'h0
// timing counts
`define CCD_CAL_CYCLES 4400
`define CCD_DLY_TAPS 8
`endif

// *** ccd_pkg.sv ***
package ccd_pkg;
    // channel divider states, gray along idle-high-low
    typedef enum logic [1:0] {
        DIV_IDLE = 2'h0,
        DIV_HIGH = 2'h1,
        DIV_LOW = 2'h3
    } ccd_div_e;
    // calibration controller states
    typedef enum logic [1:0] {
        CAL_IDLE = 2'h0,
        CAL_RUN = 2'h1,
        CAL_DONE = 2'h3
    } ccd_cal_e;
    // channel divider source select
    typedef enum logic [1:0] {
        SRC_EXT_PD = 2'h0,
        SRC_EXT_DIRECT = 2'h1,
        SRC_VCO_PD = 2'h2,
        SRC_ILLEGAL = 2'h3
    } ccd_src_e;
endpackage

// *** ccd_div_if.sv ***
`timescale 1ns/1ps
interface ccd_div_if;
    logic tick;
    logic src_lvl;
    logic hold;
    logic [3:0] m;
    logic [3:0] n;
    logic [3:0] phase;
    logic bypass;
    logic static_byp;
    logic start_hi;
    logic dcc_dis;
    logic out;
    modport ctl (output tick, src_lvl, hold, m, n, phase, bypass, static_byp,
        start_hi, dcc_dis, input out);
    modport div (input tick, src_lvl, hold, m, n, phase, bypass, static_byp,
        start_hi, dcc_dis, output out);
endinterface

// *** ccd_chan_div.sv ***
`timescale 1ns/1ps
module ccd_chan_div (
    input wire logic clk, // system clock
    input wire logic rstn, // async reset, active low
    ccd_div_if.div dif // configuration, ticks and output
);
    import ccd_pkg::*;
    ccd_div_e st_ff, nxt_st;
    logic [3:0] cnt_ff, nxt_cnt;
    logic ext_ff, nxt_ext;
    logic [4:0] d_m1;
    logic [3:0] plim;
    logic dcc_on;

    // divider sequencing on each pre-divided tick
    always_comb begin
        d_m1 = {1'b0, dif.n} + {1'b0, dif.m} + 5'h01;
        plim = ({1'b0, dif.phase} > d_m1) ? d_m1[3:0] : dif.phase;
        dcc_on = !dif.dcc_dis && ({1'b0, dif.m} == {1'b0, dif.n} + 5'h01);
        nxt_st = st_ff;
        nxt_cnt = cnt_ff;
        nxt_ext = ext_ff;
        if (dif.hold) begin
            nxt_st = DIV_IDLE;
            nxt_cnt = 4'h0;
            nxt_ext = 1'b0;
        end else if (dif.tick) begin
            nxt_ext = 1'b0;
            case (st_ff)
                DIV_IDLE: begin
                    // coarse delay counted in input cycles
                    if (cnt_ff == plim) begin
                        nxt_st = dif.start_hi ? DIV_HIGH : DIV_LOW;
                        nxt_cnt = 4'h0;
                    end else begin
                        nxt_cnt = cnt_ff + 4'h1;
                    end
                end
                DIV_HIGH: begin
                    if (cnt_ff == dif.n) begin
                        nxt_st = DIV_LOW;
                        nxt_cnt = 4'h0;
                        nxt_ext = dcc_on;
                    end else begin
                        nxt_cnt = cnt_ff + 4'h1;
                    end
                end
                DIV_LOW: begin
                    if (cnt_ff == dif.m) begin
                        nxt_st = DIV_HIGH;
                        nxt_cnt = 4'h0;
                    end else begin
                        nxt_cnt = cnt_ff + 4'h1;
                    end
                end
                default: begin
                    nxt_st = DIV_IDLE;
                    nxt_cnt = 4'h0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_ff <= DIV_IDLE;
            cnt_ff <= 4'h0;
            ext_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
            ext_ff <= nxt_ext;
        end
    end

    // half-cycle stretch only while the input is still high
    always_comb begin
        if (dif.bypass) begin
            dif.out = dif.static_byp ? 1'b0 : dif.src_lvl;
        end else begin
            dif.out = (st_ff == DIV_HIGH) | (ext_ff & dif.src_lvl);
        end
    end

    hi_len_a: assert property (@(posedge clk) disable iff (!rstn)
        (st_ff == DIV_HIGH && dif.tick && !dif.hold && cnt_ff == dif.n) |=> st_ff == DIV_LOW)
        else $error("high phase length wrong");
    lo_len_a: assert property (@(posedge clk) disable iff (!rstn)
        (st_ff == DIV_LOW && dif.tick && !dif.hold && cnt_ff != dif.m) |=> st_ff == DIV_LOW)
        else $error("low phase ended early");
    dcc_ext_a: assert property (@(posedge clk) disable iff (!rstn)
        (st_ff == DIV_HIGH && dif.tick && !dif.hold && cnt_ff == dif.n && dcc_on) |=> ext_ff)
        else $error("duty correction not applied");
    hold_idle_a: assert property (@(posedge clk) disable iff (!rstn)
        dif.hold |=> (st_ff == DIV_IDLE && cnt_ff == 4'h0))
        else $error("divider not parked under hold");
endmodule

// *** ccd_cal_ctrl.sv ***
`timescale 1ns/1ps
`include "ccd_defines.svh"
module ccd_cal_ctrl #(
    parameter int CAL_CYCLES = `CCD_CAL_CYCLES // length in calibration clocks
) (
    input wire logic clk, // system clock
    input wire logic rstn, // async reset, active low
    input wire logic ref_tick, // phase compare clock tick
    input wire logic [1:0] div_sel, // calibration divisor code
    input wire logic req, // start pulse from software
    output logic busy, // calibration running
    output logic done // calibration finished
);
    import ccd_pkg::*;
    localparam int CW = $clog2(CAL_CYCLES + 1);
    ccd_cal_e st_ff, nxt_st;
    logic [3:0] cdiv_ff, nxt_cdiv;
    logic [CW-1:0] cnt_ff, nxt_cnt;
    logic [3:0] lim;
    logic cal_tick;

    // calibration clock is the compare tick divided by 2, 4, 8 or 16
    always_comb begin
        lim = 4'((5'h02 << div_sel) - 5'h01);
        cal_tick = ref_tick && (cdiv_ff == lim);
        nxt_cdiv = cdiv_ff;
        if (ref_tick) begin
            nxt_cdiv = cal_tick ? 4'h0 : cdiv_ff + 4'h1;
        end
        nxt_st = st_ff;
        nxt_cnt = cnt_ff;
        case (st_ff)
            CAL_IDLE, CAL_DONE: begin
                if (req) begin
                    nxt_st = CAL_RUN;
                    nxt_cnt = '0;
                    nxt_cdiv = 4'h0;
                end
            end
            CAL_RUN: begin
                // a request while running is ignored
                if (cal_tick) begin
                    if (cnt_ff == CW'(CAL_CYCLES - 1)) begin
                        nxt_st = CAL_DONE;
                    end else begin
                        nxt_cnt = cnt_ff + CW'(1);
                    end
                end
            end
            default: nxt_st = CAL_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_ff <= CAL_IDLE;
            cdiv_ff <= 4'h0;
            cnt_ff <= '0;
        end else begin
            st_ff <= nxt_st;
            cdiv_ff <= nxt_cdiv;
            cnt_ff <= nxt_cnt;
        end
    end

    assign busy = (st_ff == CAL_RUN);
    assign done = (st_ff == CAL_DONE);

    cal_len_a: assert property (@(posedge clk) disable iff (!rstn)
        $rose(done) |-> $past(cnt_ff) == CW'(CAL_CYCLES - 1))
        else $error("calibration length wrong");
    no_auto_a: assert property (@(posedge clk) disable iff (!rstn)
        $rose(busy) |-> $past(req))
        else $error("calibration started without request");
    cal_release_a: assert property (@(posedge clk) disable iff (!rstn)
        $fell(busy) |-> done)
        else $error("hold released without completion");
    cal_clock_a: assert property (@(posedge clk) disable iff (!rstn)
        (busy && !cal_tick) |=> $stable(cnt_ff))
        else $error("count moved without calibration clock");
endmodule

// *** ccd_top.sv ***
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`include "ccd_defines.svh"
module ccd_top #(
    parameter int CAL_CYCLES = `CCD_CAL_CYCLES, // calibration length
    parameter int NCH = 4 // channel count
) (
    input wire logic clk, // system clock
    input wire logic rstn, // async reset, active low
    input wire logic [9:0] addr, // register address
    input wire logic [7:0] wdata, // write data
    input wire logic wr, // write strobe
    input wire logic rd, // read strobe
    output logic [7:0] rdata, // read data, cycle after rd
    input wire logic ref_tick, // phase compare clock tick
    input wire logic vco_lvl, // sampled vco level
    input wire logic ext_lvl, // sampled external clock input level
    output logic [NCH-1:0] chan_out, // channel clock outputs
    output logic hold_out, // distribution held by calibration
    output logic pfd_ref_out, // delayed reference tick to compare
    output logic pfd_fb_out // delayed feedback level to loop divider
);
    import ccd_pkg::*;

    // byte address of a channel's first register
    function automatic logic [9:0] ch_base(input int i);
        ch_base = `CCD_OFS_CH0 + 10'(i * 3);
    endfunction

    logic cal_bit_ff, nxt_cal_bit;
    logic cal_req_ff, nxt_cal_req;
    logic [1:0] cal_div_ff, nxt_cal_div;
    logic [1:0] zd_mode_ff, nxt_zd_mode;
    logic [1:0] fb_sel_ff, nxt_fb_sel;
    logic [2:0] ref_dly_ff, nxt_ref_dly;
    logic [2:0] fb_dly_ff, nxt_fb_dly;
    logic [NCH-1:0][3:0] m_ff, nxt_m;
    logic [NCH-1:0][3:0] n_ff, nxt_n;
    logic [NCH-1:0][3:0] phase_ff, nxt_phase;
    logic [NCH-1:0] byp_ff, nxt_byp;
    logic [NCH-1:0] start_ff, nxt_start;
    logic [NCH-1:0] dcc_dis_ff, nxt_dcc_dis;
    logic [NCH-1:0] direct_ff, nxt_direct;
    logic [2:0] prediv_ff, nxt_prediv;
    ccd_src_e src_ff, nxt_src;
    logic [7:0] rdata_ff, nxt_rdata;
    logic cal_busy, cal_done;

    // register writes; calibration request on a 0 to 1 write only
    always_comb begin
        nxt_cal_bit = cal_bit_ff;
        nxt_cal_req = 1'b0;
        nxt_cal_div = cal_div_ff;
        nxt_zd_mode = zd_mode_ff;
        nxt_fb_sel = fb_sel_ff;
        nxt_ref_dly = ref_dly_ff;
        nxt_fb_dly = fb_dly_ff;
        nxt_m = m_ff;
        nxt_n = n_ff;
        nxt_phase = phase_ff;
        nxt_byp = byp_ff;
        nxt_start = start_ff;
        nxt_dcc_dis = dcc_dis_ff;
        nxt_direct = direct_ff;
        nxt_prediv = prediv_ff;
        nxt_src = src_ff;
        if (wr) begin
            case (addr)
                `CCD_OFS_CAL: begin
                    nxt_cal_bit = wdata[`CCD_CAL_REQ_BIT];
                    nxt_cal_req = wdata[`CCD_CAL_REQ_BIT] & ~cal_bit_ff;
                    nxt_cal_div = wdata[`CCD_CAL_DIV_LSB +: 2];
                end
                `CCD_OFS_ZD: begin
                    nxt_zd_mode = wdata[`CCD_ZD_MODE_LSB +: 2];
                    nxt_fb_sel = wdata[`CCD_ZD_FBSEL_LSB +: 2];
                end
                `CCD_OFS_DLY: begin
                    nxt_ref_dly = wdata[2:0];
                    nxt_fb_dly = wdata[`CCD_DLY_FB_LSB +: 3];
                end
                `CCD_OFS_PREDIV: nxt_prediv = wdata[2:0];
                `CCD_OFS_SRC: nxt_src = ccd_src_e'(wdata[1:0]);
                default: ;
            endcase
            for (int i = 0; i < NCH; i++) begin
                if (addr == ch_base(i)) begin
                    nxt_m[i] = wdata[7:4];
                    nxt_n[i] = wdata[3:0];
                end
                if (addr == ch_base(i) + 10'h001) begin
                    nxt_byp[i] = wdata[`CCD_CH_BYP_BIT];
                    nxt_start[i] = wdata[`CCD_CH_START_BIT];
                    nxt_phase[i] = wdata[3:0];
                end
                if (addr == ch_base(i) + 10'h002) begin
                    nxt_dcc_dis[i] = wdata[`CCD_CH_DCC_BIT];
                    nxt_direct[i] = wdata[`CCD_CH_DIRECT_BIT];
                end
            end
        end
    end

    // read data valid only in the cycle after the strobe
    always_comb begin
        nxt_rdata = 8'h00;
        if (rd) begin
            case (addr)
                `CCD_OFS_CAL: nxt_rdata = {5'h00, cal_div_ff, cal_bit_ff};
                `CCD_OFS_ZD: nxt_rdata = {3'h0, fb_sel_ff, zd_mode_ff, 1'b0};
                `CCD_OFS_STAT: nxt_rdata = 8'(cal_done) << `CCD_STAT_DONE_BIT;
                `CCD_OFS_DLY: nxt_rdata = {2'h0, fb_dly_ff, ref_dly_ff};
                `CCD_OFS_PREDIV: nxt_rdata = {5'h00, prediv_ff};
                `CCD_OFS_SRC: nxt_rdata = {6'h00, src_ff};
                default: ;
            endcase
            for (int i = 0; i < NCH; i++) begin
                if (addr == ch_base(i)) begin
                    nxt_rdata = {m_ff[i], n_ff[i]};
                end
                if (addr == ch_base(i) + 10'h001) begin
                    nxt_rdata = {byp_ff[i], 2'h0, start_ff[i], phase_ff[i]};
                end
                if (addr == ch_base(i) + 10'h002) begin
                    nxt_rdata = {6'h00, direct_ff[i], dcc_dis_ff[i]};
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cal_bit_ff <= 1'b0;
            cal_req_ff <= 1'b0;
            cal_div_ff <= 2'h0;
            zd_mode_ff <= 2'h0;
            fb_sel_ff <= 2'h0;
            ref_dly_ff <= 3'h0;
            fb_dly_ff <= 3'h0;
            m_ff <= {NCH{`CCD_MN_RST}};
            n_ff <= {NCH{`CCD_MN_RST}};
            phase_ff <= '0;
            byp_ff <= '0;
            start_ff <= '0;
            dcc_dis_ff <= '0;
            direct_ff <= '0;
            prediv_ff <= `CCD_PREDIV_RST;
            src_ff <= SRC_VCO_PD;
            rdata_ff <= 8'h00;
        end else begin
            cal_bit_ff <= nxt_cal_bit;
            cal_req_ff <= nxt_cal_req;
            cal_div_ff <= nxt_cal_div;
            zd_mode_ff <= nxt_zd_mode;
            fb_sel_ff <= nxt_fb_sel;
            ref_dly_ff <= nxt_ref_dly;
            fb_dly_ff <= nxt_fb_dly;
            m_ff <= nxt_m;
            n_ff <= nxt_n;
            phase_ff <= nxt_phase;
            byp_ff <= nxt_byp;
            start_ff <= nxt_start;
            dcc_dis_ff <= nxt_dcc_dis;
            direct_ff <= nxt_direct;
            prediv_ff <= nxt_prediv;
            src_ff <= nxt_src;
            rdata_ff <= nxt_rdata;
        end
    end

    ccd_cal_ctrl #(.CAL_CYCLES(CAL_CYCLES)) u_cal (
        .clk(clk),
        .rstn(rstn),
        .ref_tick(ref_tick),
        .div_sel(cal_div_ff),
        .req(cal_req_ff),
        .busy(cal_busy),
        .done(cal_done)
    );

    logic src_now, src_prev_ff, nxt_src_prev, src_rise;
    logic [2:0] ratio, pd_cnt_ff, nxt_pd_cnt;
    logic tick_ff, nxt_tick, lvl_ff, nxt_lvl, static_byp;

    // source select and common pre-divider; reserved code yields no edges
    always_comb begin
        case (src_ff)
            SRC_EXT_PD, SRC_EXT_DIRECT: src_now = ext_lvl;
            SRC_VCO_PD: src_now = vco_lvl;
            default: src_now = 1'b0;
        endcase
        src_rise = src_now & ~src_prev_ff;
        nxt_src_prev = src_now;
        ratio = (prediv_ff > `CCD_PREDIV_MAX) ? 3'h0 : prediv_ff + 3'h1;
        static_byp = (src_ff != SRC_EXT_DIRECT) && (ratio == 3'h1);
        nxt_pd_cnt = pd_cnt_ff;
        nxt_tick = 1'b0;
        nxt_lvl = 1'b0;
        if (src_ff == SRC_EXT_DIRECT) begin
            nxt_pd_cnt = 3'h0;
            nxt_tick = src_rise;
            // one more cycle of lag so the high half opens each divider input cycle
            nxt_lvl = src_prev_ff;
        end else if (src_ff == SRC_ILLEGAL || ratio == 3'h0) begin
            nxt_pd_cnt = 3'h0;
        end else begin
            if (src_rise) begin
                nxt_pd_cnt = (pd_cnt_ff >= ratio - 3'h1) ? 3'h0 : pd_cnt_ff + 3'h1;
            end
            if (wr && addr == `CCD_OFS_PREDIV) begin
                nxt_pd_cnt = 3'h0; // restart so the count never exceeds a new ratio
            end
            nxt_tick = src_rise && (pd_cnt_ff == 3'h0);
            // high over the first half of each pre-divided cycle, for duty correction
            nxt_lvl = (ratio == 3'h1) ? src_prev_ff
                : ((pd_cnt_ff != 3'h0) && (pd_cnt_ff <= ((ratio + 3'h1) >> 1)));
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            src_prev_ff <= 1'b0;
            pd_cnt_ff <= 3'h0;
            tick_ff <= 1'b0;
            lvl_ff <= 1'b0;
        end else begin
            src_prev_ff <= nxt_src_prev;
            pd_cnt_ff <= nxt_pd_cnt;
            tick_ff <= nxt_tick;
            lvl_ff <= nxt_lvl;
        end
    end

    // four dividers share one tick and one hold so they stay aligned
    logic [NCH-1:0] div_out;
    ccd_div_if dif[NCH] ();
    for (genvar g = 0; g < NCH; g++) begin : g_ch
        assign dif[g].tick = tick_ff;
        assign dif[g].src_lvl = lvl_ff;
        assign dif[g].hold = cal_busy;
        assign dif[g].m = m_ff[g];
        assign dif[g].n = n_ff[g];
        assign dif[g].phase = phase_ff[g];
        assign dif[g].bypass = byp_ff[g];
        assign dif[g].static_byp = static_byp;
        assign dif[g].start_hi = start_ff[g];
        assign dif[g].dcc_dis = dcc_dis_ff[g];
        assign div_out[g] = dif[g].out;
        ccd_chan_div u_div (
            .clk(clk),
            .rstn(rstn),
            .dif(dif[g].div)
        );
    end

    logic fb_lvl;
    logic [NCH-1:0] chan_ff, nxt_chan;
    logic hold_ff;
    logic [`CCD_DLY_TAPS-1:0] ref_sr_ff, nxt_ref_sr, fb_sr_ff, nxt_fb_sr;
    logic pfd_ref_ff, pfd_fb_ff, nxt_pfd_ref, nxt_pfd_fb;

    // output routing, feedback selection and loop path delays
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            if (direct_ff[i] && src_ff == SRC_VCO_PD) begin
                nxt_chan[i] = vco_lvl & ~cal_busy;
            end else begin
                nxt_chan[i] = div_out[i] & ~cal_busy;
            end
        end
        case (zd_mode_ff)
            `CCD_ZD_INT: fb_lvl = div_out[fb_sel_ff];
            `CCD_ZD_EXT: fb_lvl = ext_lvl;
            default: fb_lvl = vco_lvl;
        endcase
        nxt_ref_sr = {ref_sr_ff[`CCD_DLY_TAPS-2:0], ref_tick};
        nxt_fb_sr = {fb_sr_ff[`CCD_DLY_TAPS-2:0], fb_lvl};
        nxt_pfd_ref = ref_sr_ff[ref_dly_ff];
        nxt_pfd_fb = fb_sr_ff[fb_dly_ff];
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            chan_ff <= '0;
            hold_ff <= 1'b0;
            ref_sr_ff <= '0;
            fb_sr_ff <= '0;
            pfd_ref_ff <= 1'b0;
            pfd_fb_ff <= 1'b0;
        end else begin
            chan_ff <= nxt_chan;
            hold_ff <= cal_busy;
            ref_sr_ff <= nxt_ref_sr;
            fb_sr_ff <= nxt_fb_sr;
            pfd_ref_ff <= nxt_pfd_ref;
            pfd_fb_ff <= nxt_pfd_fb;
        end
    end

    assign rdata = rdata_ff;
    assign chan_out = chan_ff;
    assign hold_out = hold_ff;
    assign pfd_ref_out = pfd_ref_ff;
    assign pfd_fb_out = pfd_fb_ff;

    cal_hold_a: assert property (@(posedge clk) disable iff (!rstn)
        cal_busy |=> (hold_out && chan_out == '0))
        else $error("outputs not held during calibration");
    zd_int_a: assert property (@(posedge clk) disable iff (!rstn)
        zd_mode_ff == `CCD_ZD_INT |=> fb_sr_ff[0] == $past(div_out[fb_sel_ff]))
        else $error("internal feedback channel wrong");
    zd_ext_a: assert property (@(posedge clk) disable iff (!rstn)
        zd_mode_ff == `CCD_ZD_EXT |=> fb_sr_ff[0] == $past(ext_lvl))
        else $error("external feedback not taken");
    src_park_a: assert property (@(posedge clk) disable iff (!rstn)
        src_ff == SRC_ILLEGAL |=> (!tick_ff && !lvl_ff))
        else $error("reserved source not parked");
    vco_direct_a: assert property (@(posedge clk) disable iff (!rstn)
        (direct_ff[0] && src_ff == SRC_VCO_PD && !cal_busy) |=> chan_out[0] == $past(vco_lvl))
        else $error("direct vco path wrong");
    prediv_rng_a: assert property (@(posedge clk) disable iff (!rstn)
        (src_ff != SRC_EXT_DIRECT && ratio != 3'h0) |-> pd_cnt_ff < ratio)
        else $error("pre-divider count out of range");
endmodule

// *** ccd_src_model.sv ***
`timescale 1ns/1ps
module ccd_src_model (
    input wire logic clk, // system clock
    input wire logic rstn, // reset, active low
    output logic ref_tick, // compare tick
    output logic vco_lvl, // vco level
    output logic ext_lvl // external clock level
);
    logic [1:0] cnt_ff;
    // free running sources: ext at clk/2, vco at clk/4
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) cnt_ff <= 2'h0;
        else cnt_ff <= cnt_ff + 2'h1;
    end
    assign ext_lvl = cnt_ff[0];
    assign vco_lvl = cnt_ff[1];
    assign ref_tick = rstn; // tick every cycle keeps calibration short
endmodule

// *** clock_distribution_divider_control_tb_top.sv ***
`timescale 1ns/1ps
module clock_distribution_divider_control_tb_top;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [9:0] addr = 10'h000;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata, v;
    logic [3:0] chan_out;
    logic ref_tick, vco_lvl, ext_lvl, hold_out, pfd_ref_out, pfd_fb_out;
    int n_fail = 0;
    int checked = 0;
    always #20 clk = ~clk;
    ccd_src_model ccd_src_model_i (.clk(clk), .rstn(rstn), .ref_tick(ref_tick),
        .vco_lvl(vco_lvl), .ext_lvl(ext_lvl));
    ccd_top #(.CAL_CYCLES(8)) ccd_top_i (.clk(clk), .rstn(rstn), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .ref_tick(ref_tick),
        .vco_lvl(vco_lvl), .ext_lvl(ext_lvl), .chan_out(chan_out),
        .hold_out(hold_out), .pfd_ref_out(pfd_ref_out), .pfd_fb_out(pfd_fb_out));
    // one compare for every byte-sized result
    task automatic cmp8(input string what, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %0h seen %0h", what, e, g);
        end
    endtask
    // bus cycles: strobes launched just after a rising edge
    task automatic wr_reg(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [9:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask
    // length of one full high phase, sampled at falling edges
    task automatic meas_hi(output int hi);
        hi = 0;
        for (int i = 0; i < 60 && chan_out[0] !== 1'b0; i++) @(negedge clk);
        for (int i = 0; i < 60 && chan_out[0] !== 1'b1; i++) @(negedge clk);
        for (int i = 0; i < 60 && chan_out[0] === 1'b1; i++) begin
            hi++;
            @(negedge clk);
        end
    endtask
    task automatic div_case(input logic [7:0] s, p, mn, input int e);
        int hi;
        wr_reg(10'h1E1, s);
        wr_reg(10'h1E0, p);
        wr_reg(10'h190, mn);
        repeat (30) @(posedge clk);
        meas_hi(hi);
        cmp8("chan0 high", e[7:0], hi[7:0]);
    endtask
    task automatic t_reset;
        rd_reg(10'h1E1, v);
        cmp8("source", 8'h02, v);
        rd_reg(10'h1E0, v);
        cmp8("prediv", 8'h01, v);
        rd_reg(10'h3FF, v);
        cmp8("unmapped", 8'h00, v);
    endtask
    // ext edge every 2 clocks, so one input cycle is 2 clocks direct
    task automatic t_divide;
        div_case(8'h01, 8'h01, 8'h20, 2);
        div_case(8'h01, 8'h01, 8'h02, 6);
        div_case(8'h00, 8'h01, 8'h00, 4);
        div_case(8'h00, 8'h05, 8'h00, 12);
        div_case(8'h01, 8'h01, 8'h10, 3);
    endtask
    // feedback routing, loop delay, vco direct and bypass; ch0 by 3, ch1 by 2
    task automatic t_route;
        logic pv;
        int hi;
        wr_reg(10'h020, 8'h08);
        wr_reg(10'h01E, 8'h06);
        repeat (4) @(negedge clk);
        repeat (8) begin
            @(negedge clk);
            cmp8("fb ext", {7'h00, ~ext_lvl}, {7'h00, pfd_fb_out});
        end
        cmp8("ref path", 8'h01, {7'h00, pfd_ref_out});
        wr_reg(10'h020, 8'h00);
        wr_reg(10'h01E, 8'h0A);
        repeat (4) @(negedge clk);
        repeat (8) begin
            pv = chan_out[1];
            @(negedge clk);
            cmp8("fb int", {7'h00, pv}, {7'h00, pfd_fb_out});
        end
        wr_reg(10'h1E1, 8'h02);
        wr_reg(10'h192, 8'h02);
        repeat (2) @(negedge clk);
        repeat (8) begin
            pv = vco_lvl;
            @(negedge clk);
            cmp8("vco direct", {7'h00, pv}, {7'h00, chan_out[0]});
        end
        wr_reg(10'h1E1, 8'h00);
        wr_reg(10'h191, 8'h80);
        repeat (4) @(posedge clk);
        meas_hi(hi);
        cmp8("bypass high", 8'h02, hi[7:0]);
    endtask
    // outputs toggling when the run starts, so a missing hold shows
    task automatic t_cal;
        int cnt, bad;
        cnt = 0;
        bad = 0;
        rd_reg(10'h01F, v);
        cmp8("no self start", 8'h00, v);
        wr_reg(10'h018, 8'h01);
        for (int i = 0; i < 8 && hold_out !== 1'b1; i++) @(negedge clk);
        for (int i = 0; i < 60 && hold_out === 1'b1; i++) begin
            cnt++;
            if (chan_out !== 4'h0) bad++;
            @(negedge clk);
        end
        cmp8("hold length ok", 8'h01, {7'h00, cnt >= 16 && cnt <= 18});
        cmp8("held static", 8'h00, bad[7:0]);
        rd_reg(10'h01F, v);
        cmp8("done flag", 8'h40, v);
    endtask
    // reserved source code stops the ticks and holds bypassed chan0 low
    task automatic t_illegal;
        int ones;
        ones = 0;
        wr_reg(10'h1E1, 8'h03);
        repeat (4) @(posedge clk);
        repeat (40) begin
            @(negedge clk);
            if (chan_out[0] !== 1'b0) ones++;
        end
        cmp8("illegal src out", 8'h00, ones[7:0]);
    endtask
    task automatic tally_and_finish;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_divide();
        t_route();
        t_cal();
        t_illegal();
        tally_and_finish();
    end
    // run needs well under 1000 cycles
    initial begin
        #200000;
        n_fail++;
        tally_and_finish();
    end
endmodule
